/* rtmc_map.svh */
`ifndef RTMC_MAP_SVH
`define RTMC_MAP_SVH
`define RTMC_MISC_ADDR 8'h0a
`define RTMC_MISC_RST 8'hb1
`define RTMC_B_ROLE 7
`define RTMC_B_GATE 6
`define RTMC_B_ADA 5
`define RTMC_B_EQON 4
`define RTMC_B_RSVD 3
`define RTMC_B_COMMIT 2
`define RTMC_F_FMODE 1:0
`define RTMC_FMODE_RST 2'h1
`define RTMC_LANE_W 15
`define RTMC_BYTE_BITS 4'h8
`define RTMC_CNT_ONE 4'h1
`define RTMC_CNT_ZERO 4'h0
`define RTMC_PIN_RST 6'h18
`define RTMC_BUS_PIN_RST 2'h3
`define RTMC_READ_ZERO 8'h00
`endif

/* rtmc_pkg.sv */
`include "rtmc_map.svh"
package rtmc_pkg;
	typedef enum logic [1:0] {
		RTMC_FM_REDRIVER = 2'b00,
		RTMC_FM_AUTO = 2'b01,
		RTMC_FM_RSVD = 2'b10,
		RTMC_FM_RETIMER = 2'b11
	} rtmc_fmode_t;

	typedef enum logic [3:0] {
		RTMC_I_IDLE = 4'b0000,
		RTMC_I_ADDR = 4'b0001,
		RTMC_I_ACK_A = 4'b0010,
		RTMC_I_PTR = 4'b0011,
		RTMC_I_ACK_P = 4'b0100,
		RTMC_I_WDATA = 4'b0101,
		RTMC_I_ACK_W = 4'b0110,
		RTMC_I_RDATA = 4'b0111,
		RTMC_I_RACK = 4'b1000,
		RTMC_I_RLOAD = 4'b1001
	} rtmc_i2c_state_t;

	typedef struct packed {
		rtmc_i2c_state_t state;
		logic [3:0] bitcnt;
		logic [7:0] shreg;
		logic [7:0] ptr;
		logic rw;
		logic sda_oe;
		logic scl_q;
		logic sda_q;
		logic wr;
		logic [7:0] wr_addr;
		logic [7:0] wr_data;
	} rtmc_i2c_st_t;

	typedef struct packed {
		logic role_sink;
		logic gate;
		logic eq_ada;
		logic eq_on;
		rtmc_fmode_t fmode;
		logic [`RTMC_LANE_W-1:0] lane_cfg;
		logic lane_eq_on;
		logic lane_eq_ada;
		rtmc_fmode_t fmode_act;
		logic src_hp;
		logic pwr_dn;
		logic rx_stby;
		logic commit;
	} rtmc_regs_st_t;
endpackage

/* rtmc_sync.sv */
`timescale 1ns/1ps
module rtmc_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} rtmc_sync_st_t;

	rtmc_sync_st_t st_ff;
	rtmc_sync_st_t nxt_st;

	// A bit only moves once stages two and three agree, which filters a single-cycle glitch.
	always_comb begin
		nxt_st = st_ff;
		nxt_st.s1 = d_i;
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
		nxt_st.q = (~(st_ff.s2 ^ st_ff.s3) & st_ff.s3) | ((st_ff.s2 ^ st_ff.s3) & st_ff.q);
	end

	// Register the whole state.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			st_ff <= {RST, RST, RST, RST};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign q_o = st_ff.q;
endmodule // rtmc_sync

/* rtmc_i2c_slave.sv */
`timescale 1ns/1ps
`include "rtmc_map.svh"
module rtmc_i2c_slave import rtmc_pkg::*; #(
	parameter logic [6:0] DEV_ADDR = 7'h2c // Arbitrary value.
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic scl_s_i,
	input wire logic sda_s_i,
	output logic sda_o,
	output logic sda_oe_o,
	output logic wr_o,
	output logic [7:0] wr_addr_o,
	output logic [7:0] wr_data_o,
	output logic [7:0] rd_addr_o,
	input wire logic [7:0] rd_data_i
);
	rtmc_i2c_st_t st_ff;
	rtmc_i2c_st_t nxt_st;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;

	// Bus events from the synchronised pins; data changes while SCL is high mark start and stop.
	assign scl_rise = scl_s_i && !st_ff.scl_q;
	assign scl_fall = !scl_s_i && st_ff.scl_q;
	assign start_c = scl_s_i && st_ff.scl_q && st_ff.sda_q && !sda_s_i;
	assign stop_c = scl_s_i && st_ff.scl_q && !st_ff.sda_q && sda_s_i;

	// Byte engine: address, register pointer, then auto-incrementing data bytes.
	always_comb begin
		nxt_st = st_ff;
		nxt_st.scl_q = scl_s_i;
		nxt_st.sda_q = sda_s_i;
		nxt_st.wr = 1'b0;
		if (start_c) begin
			nxt_st.state = RTMC_I_ADDR;
			nxt_st.bitcnt = `RTMC_CNT_ZERO;
			nxt_st.sda_oe = 1'b0;
		end else if (stop_c) begin
			nxt_st.state = RTMC_I_IDLE;
			nxt_st.sda_oe = 1'b0;
		end else if (scl_rise) begin
			case (st_ff.state)
				RTMC_I_ADDR, RTMC_I_PTR, RTMC_I_WDATA: begin
					nxt_st.shreg = {st_ff.shreg[6:0], sda_s_i};
					nxt_st.bitcnt = st_ff.bitcnt + `RTMC_CNT_ONE;
				end
				RTMC_I_RACK: begin
					// A not-acknowledge ends the read burst.
					if (sda_s_i) begin
						nxt_st.state = RTMC_I_IDLE;
					end else begin
						nxt_st.ptr = st_ff.ptr + 8'h01;
						nxt_st.state = RTMC_I_RLOAD;
					end
				end
				default: begin
				end
			endcase
		end else if (scl_fall) begin
			case (st_ff.state)
				RTMC_I_ADDR: begin
					if (st_ff.bitcnt == `RTMC_BYTE_BITS) begin
						if (st_ff.shreg[7:1] == DEV_ADDR) begin
							nxt_st.sda_oe = 1'b1;
							nxt_st.rw = st_ff.shreg[0];
							nxt_st.state = RTMC_I_ACK_A;
						end else begin
							nxt_st.state = RTMC_I_IDLE;
						end
					end
				end
				RTMC_I_ACK_A: begin
					nxt_st.bitcnt = `RTMC_CNT_ZERO;
					if (st_ff.rw) begin
						nxt_st.shreg = rd_data_i;
						nxt_st.sda_oe = !rd_data_i[7];
						nxt_st.bitcnt = `RTMC_CNT_ONE;
						nxt_st.state = RTMC_I_RDATA;
					end else begin
						nxt_st.sda_oe = 1'b0;
						nxt_st.state = RTMC_I_PTR;
					end
				end
				RTMC_I_PTR, RTMC_I_WDATA: begin
					if (st_ff.bitcnt == `RTMC_BYTE_BITS) begin
						nxt_st.sda_oe = 1'b1;
						if (st_ff.state == RTMC_I_PTR) begin
							nxt_st.ptr = st_ff.shreg;
							nxt_st.state = RTMC_I_ACK_P;
						end else begin
							nxt_st.wr = 1'b1;
							nxt_st.wr_addr = st_ff.ptr;
							nxt_st.wr_data = st_ff.shreg;
							nxt_st.state = RTMC_I_ACK_W;
						end
					end
				end
				RTMC_I_ACK_P, RTMC_I_ACK_W: begin
					nxt_st.sda_oe = 1'b0;
					nxt_st.bitcnt = `RTMC_CNT_ZERO;
					nxt_st.state = RTMC_I_WDATA;
					if (st_ff.state == RTMC_I_ACK_W) begin
						nxt_st.ptr = st_ff.ptr + 8'h01;
					end
				end
				RTMC_I_RDATA: begin
					if (st_ff.bitcnt == `RTMC_BYTE_BITS) begin
						nxt_st.sda_oe = 1'b0;
						nxt_st.state = RTMC_I_RACK;
					end else begin
						nxt_st.shreg = {st_ff.shreg[6:0], 1'b0};
						nxt_st.sda_oe = !st_ff.shreg[6];
						nxt_st.bitcnt = st_ff.bitcnt + `RTMC_CNT_ONE;
					end
				end
				RTMC_I_RLOAD: begin
					nxt_st.shreg = rd_data_i;
					nxt_st.sda_oe = !rd_data_i[7];
					nxt_st.bitcnt = `RTMC_CNT_ONE;
					nxt_st.state = RTMC_I_RDATA;
				end
				default: begin
				end
			endcase
		end
	end

	// Register the whole state; the bus idles high after reset.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			st_ff <= '{state: RTMC_I_IDLE, scl_q: 1'b1, sda_q: 1'b1, default: '0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign sda_o = 1'b0; // Open drain: only ever pulls low.
	assign sda_oe_o = st_ff.sda_oe;
	assign wr_o = st_ff.wr;
	assign wr_addr_o = st_ff.wr_addr;
	assign wr_data_o = st_ff.wr_data;
	assign rd_addr_o = st_ff.ptr;
endmodule // rtmc_i2c_slave

/* rtmc_misc_regs.sv */
// Functional notes
// - Autosleep-off clear: power down follows sink hot-plug; set: never auto power down.
// - Bit 7 picks role: zero source side, one sink side, sink after reset.
// - Gate clear passes sink hot-plug to source output; set holds it low.
// - Equalizer mode bit: zero fixed, one adaptive, adaptive after reset.
// - Equalizer enable bit: zero off, one on, on after reset.
// - With host-config select low, equalizer bit writes are ignored; straps rule.
// - Commit bit is write-only, self-clearing; one applies staged lane settings.
// - Lane setting writes are only staged until a commit.
// - Staged values act directly while lanes idle, powered down, or clockless with clock detection on.
// - Function mode: 00 redriver, 01 auto crossover (reset), 10 reserved, 11 retimer.
// - Forced power down gives the lowest-power state; clear is normal operation.
// - With clock detection on, receiver stands by without clock; else normal.
`timescale 1ns/1ps
`include "rtmc_map.svh"
module rtmc_misc_regs import rtmc_pkg::*; #(
	parameter logic [6:0] DEV_ADDR = 7'h2c // Arbitrary value.
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic host_cfg_sel_i,
	input wire logic strap_equalizer_on_i,
	input wire logic strap_adaptive_equalizer_sel_i,
	input wire logic oe_i,
	input wire logic sink_hotplug_in_i,
	input wire logic link_clock_present_i,
	input wire logic forced_power_down_i,
	input wire logic clock_activity_detect_en_i,
	input wire logic hotplug_autosleep_off_i,
	input wire logic [`RTMC_LANE_W-1:0] pending_lane_cfg_i,
	output logic source_hotplug_out_o,
	output logic power_down_o,
	output logic rx_standby_o,
	output logic app_role_sink_o,
	output rtmc_pkg::rtmc_fmode_t lane_function_mode_o,
	output logic [`RTMC_LANE_W-1:0] lane_cfg_o,
	output logic lane_equalizer_on_o,
	output logic lane_adaptive_equalizer_sel_o,
	output logic commit_lane_settings_o
);
	import rtmc_pkg::*;

	// Reset image of the control byte, so single reset bits are picked without truncation.
	localparam logic [7:0] RST_BYTE = `RTMC_MISC_RST;

	rtmc_regs_st_t st_ff;
	rtmc_regs_st_t nxt_st;
	logic [1:0] bus_s;
	logic [5:0] pin_s;
	logic host_sel_s;
	logic strap_on_s;
	logic strap_ada_s;
	logic oe_s;
	logic sink_hp_s;
	logic clk_pres_s;
	logic wr;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic [7:0] rd_addr;
	logic [7:0] rd_data;
	logic misc_wr;
	logic commit_wr;
	logic direct_apply;

	// The bus pins SCL and SDA arrive from outside the clock domain.
	rtmc_sync #(
		.W(2),
		.RST(`RTMC_BUS_PIN_RST)
	) u_bus_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.d_i({scl_i, sda_i}),
		.q_o(bus_s)
	);

	// Straps and board levels are just as asynchronous; equalizer straps idle high.
	rtmc_sync #(
		.W(6),
		.RST(`RTMC_PIN_RST)
	) u_pin_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.d_i({host_cfg_sel_i, strap_equalizer_on_i, strap_adaptive_equalizer_sel_i,
			oe_i, sink_hotplug_in_i, link_clock_present_i}),
		.q_o(pin_s)
	);

	assign host_sel_s = pin_s[5];
	assign strap_on_s = pin_s[4];
	assign strap_ada_s = pin_s[3];
	assign oe_s = pin_s[2];
	assign sink_hp_s = pin_s[1];
	assign clk_pres_s = pin_s[0];

	rtmc_i2c_slave #(
		.DEV_ADDR(DEV_ADDR)
	) u_slave (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.scl_s_i(bus_s[1]),
		.sda_s_i(bus_s[0]),
		.sda_o(sda_o),
		.sda_oe_o(sda_oe_o),
		.wr_o(wr),
		.wr_addr_o(wr_addr),
		.wr_data_o(wr_data),
		.rd_addr_o(rd_addr),
		.rd_data_i(rd_data)
	);

	// Read view of the control byte; the commit and reserved bits always read zero.
	always_comb begin
		rd_data = `RTMC_READ_ZERO;
		if (rd_addr == `RTMC_MISC_ADDR) begin
			rd_data[`RTMC_B_ROLE] = st_ff.role_sink;
			rd_data[`RTMC_B_GATE] = st_ff.gate;
			rd_data[`RTMC_B_ADA] = st_ff.eq_ada;
			rd_data[`RTMC_B_EQON] = st_ff.eq_on;
			rd_data[`RTMC_F_FMODE] = st_ff.fmode;
		end
	end

	assign misc_wr = wr && (wr_addr == `RTMC_MISC_ADDR);
	assign commit_wr = misc_wr && wr_data[`RTMC_B_COMMIT];
	// No commit is needed while the lanes cannot be carrying traffic.
	assign direct_apply = !oe_s || !sink_hp_s || forced_power_down_i ||
		(clock_activity_detect_en_i && !clk_pres_s);

	// Next state of the control byte, the applied lane set and the derived power levels.
	always_comb begin
		nxt_st = st_ff;
		nxt_st.commit = 1'b0;
		if (misc_wr) begin
			nxt_st.role_sink = wr_data[`RTMC_B_ROLE];
			nxt_st.gate = wr_data[`RTMC_B_GATE];
			nxt_st.fmode = rtmc_fmode_t'(wr_data[`RTMC_F_FMODE]);
			nxt_st.commit = wr_data[`RTMC_B_COMMIT];
			if (host_sel_s) begin
				nxt_st.eq_ada = wr_data[`RTMC_B_ADA];
				nxt_st.eq_on = wr_data[`RTMC_B_EQON];
			end
		end
		// Without host configuration the straps own both equalizer bits.
		if (!host_sel_s) begin
			nxt_st.eq_ada = strap_ada_s;
			nxt_st.eq_on = strap_on_s;
		end
		// Staged values reach the lanes only on commit or while traffic is impossible.
		if (commit_wr || direct_apply) begin
			nxt_st.lane_cfg = pending_lane_cfg_i;
			nxt_st.lane_eq_on = nxt_st.eq_on;
			nxt_st.lane_eq_ada = nxt_st.eq_ada;
		end
		nxt_st.pwr_dn = forced_power_down_i || (!hotplug_autosleep_off_i && !sink_hp_s);
		// A new function mode is picked up only while powered down, so it needs a toggle.
		if (st_ff.pwr_dn) begin
			nxt_st.fmode_act = st_ff.fmode;
		end
		nxt_st.src_hp = sink_hp_s && !st_ff.gate;
		nxt_st.rx_stby = clock_activity_detect_en_i && !clk_pres_s;
	end

	// Register the whole state; the control byte resets to its documented value.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			st_ff <= '{
				role_sink: RST_BYTE[`RTMC_B_ROLE],
				eq_ada: RST_BYTE[`RTMC_B_ADA],
				eq_on: RST_BYTE[`RTMC_B_EQON],
				fmode: RTMC_FM_AUTO,
				lane_eq_on: RST_BYTE[`RTMC_B_EQON],
				lane_eq_ada: RST_BYTE[`RTMC_B_ADA],
				fmode_act: RTMC_FM_AUTO,
				default: '0
			};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign source_hotplug_out_o = st_ff.src_hp;
	assign power_down_o = st_ff.pwr_dn;
	assign rx_standby_o = st_ff.rx_stby;
	assign app_role_sink_o = st_ff.role_sink;
	assign lane_function_mode_o = st_ff.fmode_act;
	assign lane_cfg_o = st_ff.lane_cfg;
	assign lane_equalizer_on_o = st_ff.lane_eq_on;
	assign lane_adaptive_equalizer_sel_o = st_ff.lane_eq_ada;
	assign commit_lane_settings_o = st_ff.commit;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence s_commit_wr;
		commit_wr && !direct_apply;
	endsequence

	sequence s_host_eq_wr;
		misc_wr && host_sel_s;
	endsequence

	property p_autosleep;
		!forced_power_down_i |=> power_down_o == (!$past(hotplug_autosleep_off_i) &&
			!$past(sink_hp_s));
	endproperty
	a_autosleep: assert property (p_autosleep) else $error("auto power down wrong");

	property p_role;
		misc_wr |=> app_role_sink_o == $past(wr_data[`RTMC_B_ROLE]);
	endproperty
	a_role: assert property (p_role) else $error("role bit not stored");

	property p_gate;
		st_ff.gate |=> !source_hotplug_out_o;
	endproperty
	a_gate: assert property (p_gate) else $error("gated hot-plug leaked");

	property p_eq_host;
		s_host_eq_wr ##1 !misc_wr && host_sel_s |-> st_ff.eq_ada == $past(wr_data[`RTMC_B_ADA])
			&& st_ff.eq_on == $past(wr_data[`RTMC_B_EQON]);
	endproperty
	a_eq_host: assert property (p_eq_host) else $error("equalizer bits not written");

	property p_eq_strap;
		!host_sel_s |=> st_ff.eq_on == $past(strap_on_s) && st_ff.eq_ada == $past(strap_ada_s);
	endproperty
	a_eq_strap: assert property (p_eq_strap) else $error("strap override lost");

	property p_commit;
		s_commit_wr |=> lane_cfg_o == $past(pending_lane_cfg_i) && commit_lane_settings_o
			##1 !commit_lane_settings_o || $past(commit_wr);
	endproperty
	a_commit: assert property (p_commit) else $error("commit did not apply");

	property p_staged;
		!commit_wr && !direct_apply |=> $stable(lane_cfg_o);
	endproperty
	a_staged: assert property (p_staged) else $error("lane set moved without commit");

	property p_direct;
		direct_apply |=> lane_cfg_o == $past(pending_lane_cfg_i);
	endproperty
	a_direct: assert property (p_direct) else $error("direct apply failed");

	property p_fmode;
		power_down_o ##1 power_down_o |=> lane_function_mode_o == $past(st_ff.fmode);
	endproperty
	a_fmode: assert property (p_fmode) else $error("mode not taken in power down");

	property p_forced_pd;
		forced_power_down_i |=> power_down_o;
	endproperty
	a_forced_pd: assert property (p_forced_pd) else $error("forced power down ignored");

	property p_standby;
		clock_activity_detect_en_i == 1'b0 |=> !rx_standby_o;
	endproperty
	a_standby: assert property (p_standby) else $error("standby without detection");

	property p_rsvd_read;
		rd_data[`RTMC_B_COMMIT] == 1'b0 && rd_data[`RTMC_B_RSVD] == 1'b0;
	endproperty
	a_rsvd_read: assert property (p_rsvd_read) else $error("write-only bit read back");
endmodule // rtmc_misc_regs

/* rtmc_host_model.sv */
`timescale 1ns/1ps
module rtmc_host_model (
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_oe_o
);
	// The bus idles released, with SCL standing high between frames.
	initial begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
	end
	// Eight clocks per phase stay clear of the slave's input synchroniser delay.
	task automatic hold(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	// Also serves as a repeated start, since it first releases SDA with SCL low.
	task automatic start();
		sda_oe_o = 1'b0;
		hold(8);
		scl_o = 1'b1;
		hold(8);
		sda_oe_o = 1'b1;
		hold(8);
		scl_o = 1'b0;
		hold(8);
	endtask
	task automatic stop();
		sda_oe_o = 1'b1;
		hold(8);
		scl_o = 1'b1;
		hold(8);
		sda_oe_o = 1'b0;
		hold(8);
	endtask
	// The line is sampled late in the high phase, after the slave has settled it.
	task automatic bit_x(input logic b, output logic s);
		sda_oe_o = ~b;
		hold(8);
		scl_o = 1'b1;
		hold(8);
		s = sda_i;
		scl_o = 0;
		hold(4);
	endtask
	task automatic byte_x(input logic [7:0] d, input logic m, output logic [7:0] q,
		output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], q[i]);
		end
		bit_x(m, b);
		ack = ~b;
	endtask
	task automatic wr_reg(input logic [6:0] dev, input logic [7:0] p, input logic [7:0] d,
		output logic ok);
		logic [7:0] q;
		logic a0, a1, a2;
		start();
		byte_x({dev, 1'b0}, 1'b1, q, a0);
		byte_x(p, 1'b1, q, a1);
		byte_x(d, 1'b1, q, a2);
		stop();
		ok = a0 & a1 & a2;
	endtask
	// A read ends with a master NACK so the slave lets go of the line.
	task automatic rd_reg(input logic [6:0] dev, input logic [7:0] p, output logic [7:0] d,
		output logic ok);
		logic [7:0] q;
		logic a0, a1, a2, a3;
		start();
		byte_x({dev, 1'b0}, 1'b1, q, a0);
		byte_x(p, 1'b1, q, a1);
		start();
		byte_x({dev, 1'b1}, 1'b1, q, a2);
		byte_x(8'hff, 1'b1, d, a3);
		stop();
		ok = a0 & a1 & a2;
	endtask
endmodule // rtmc_host_model

/* rtmc_misc_regs_tb.sv */
`timescale 1ns/1ps
`include "rtmc_map.svh"
module rtmc_misc_regs_tb;
	import rtmc_pkg::*;
	localparam logic [6:0] DEV = 7'h2c; // Arbitrary value.
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic host_cfg_sel_i = 1'b1;
	logic st_on = 1'b1;
	logic st_ada = 1'b1;
	logic oe_i = 1'b1;
	logic shp = 1'b1;
	logic clkp = 1'b1;
	logic fpd = 1'b0;
	logic det = 1'b0;
	logic aso = 1'b0;
	logic [`RTMC_LANE_W-1:0] pend = '0;
	logic [`RTMC_LANE_W-1:0] lcfg;
	logic scl, hoe, sda, sda_o, sda_oe_o, src_hp, pd, stby, role, leq, lada, cmt;
	rtmc_fmode_t fm;
	logic [31:0] seed = 32'h00008d73;
	int mismatches = 0;
	int tests_run = 0;
	int pulses = 0;
	// Open-drain line with a pull-up: low whenever either side pulls.
	assign sda = ~hoe & (sda_oe_o ? sda_o : 1'b1);
	rtmc_misc_regs #(.DEV_ADDR(DEV)) dut (.clk_i, .rst_n_i, .scl_i(scl), .sda_i(sda), .sda_o,
		.sda_oe_o, .host_cfg_sel_i, .strap_equalizer_on_i(st_on),
		.strap_adaptive_equalizer_sel_i(st_ada), .oe_i, .sink_hotplug_in_i(shp),
		.link_clock_present_i(clkp), .forced_power_down_i(fpd),
		.clock_activity_detect_en_i(det), .hotplug_autosleep_off_i(aso),
		.pending_lane_cfg_i(pend), .source_hotplug_out_o(src_hp), .power_down_o(pd),
		.rx_standby_o(stby), .app_role_sink_o(role), .lane_function_mode_o(fm),
		.lane_cfg_o(lcfg), .lane_equalizer_on_o(leq), .lane_adaptive_equalizer_sel_o(lada),
		.commit_lane_settings_o(cmt));
	rtmc_host_model host (.clk_i, .sda_i(sda), .scl_o(scl), .sda_oe_o(hoe));
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	// Counting pulses catches both a missing and a stuck commit strobe.
	always @(posedge clk_i) begin
		if (cmt === 1'b1) pulses <= pulses + 1;
	end
	function automatic void step();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
	endfunction
	// Readback: bits 3 and 2 read zero; with host select low the straps own the eq bits.
	function automatic logic [7:0] exp_rd(logic [7:0] d, logic sel, logic son, logic sada);
		return sel ? (d & 8'hf3) : {d[7:6], sada, son, 2'b00, d[1:0]};
	endfunction
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		logic ok;
		host.wr_reg(DEV, p, d, ok);
		chk("write ack", 16'h0001, {15'h0, ok});
	endtask
	task automatic rd(input logic [7:0] p, output logic [7:0] q);
		logic ok;
		host.rd_reg(DEV, p, q, ok);
		chk("read ack", 16'h0001, {15'h0, ok});
	endtask
	task automatic wrap_up();
		if (mismatches == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Main sequence; all inputs change on the falling edge.
	initial begin
		logic [7:0] q, d;
		logic [`RTMC_LANE_W-1:0] applied;
		logic [1:0] prevm;
		logic ok;
		int c0;
		repeat (4) @(negedge clk_i);
		rst_n_i = 1'b1;
		@(negedge clk_i);
		chk("reset outputs", 16'h005c, {9'h0, role, fm, leq, lada, cmt, sda_oe_o});
		rd(8'h0a, q);
		chk("reset value", {8'h00, `RTMC_MISC_RST}, {8'h00, q});
		for (int i = 0; i < 6; i++) begin
			step();
			d = (i == 0) ? 8'hfb : (i == 1) ? 8'h00 : (seed[7:0] & 8'hfb);
			wr(8'h0a, d);
			rd(8'h0a, q);
			chk("readback", {8'h00, exp_rd(d, 1'b1, 1'b0, 1'b0)}, {8'h00, q});
			chk("role", {15'h0, d[7]}, {15'h0, role});
		end
		host_cfg_sel_i = 1'b0;
		for (int i = 0; i < 3; i++) begin
			step();
			st_on = seed[8];
			st_ada = seed[9];
			repeat (8) @(negedge clk_i);
			d = {seed[7:6], ~st_ada, ~st_on, seed[3], 1'b0, seed[1:0]};
			wr(8'h0a, d);
			rd(8'h0a, q);
			chk("strap eq", {8'h00, exp_rd(d, 1'b0, st_on, st_ada)}, {8'h00, q});
		end
		host_cfg_sel_i = 1'b1;
		repeat (8) @(negedge clk_i);
		for (int g = 0; g < 2; g++) begin
			wr(8'h0a, g[0] ? 8'hf1 : 8'hb1);
			for (int i = 0; i < 32; i++) begin
				{fpd, aso, shp, det, clkp} = i[4:0];
				repeat (8) @(negedge clk_i);
				chk("power down", {15'h0, fpd | (~aso & ~shp)}, {15'h0, pd});
				chk("source hotplug", {15'h0, shp & ~g[0]}, {15'h0, src_hp});
				chk("rx standby", {15'h0, det & ~clkp}, {15'h0, stby});
			end
		end
		// Each quiet condition alone lets staged values through without a commit.
		for (int k = 0; k < 4; k++) begin
			oe_i = (k != 0);
			shp = (k != 1);
			fpd = (k == 2);
			det = (k == 3);
			clkp = (k != 3);
			step();
			pend = seed[`RTMC_LANE_W-1:0];
			repeat (8) @(negedge clk_i);
			chk("direct apply", {1'b0, pend}, {1'b0, lcfg});
		end
		{oe_i, shp, fpd, det, clkp} = 5'h19;
		applied = pend;
		repeat (8) @(negedge clk_i);
		step();
		pend = seed[`RTMC_LANE_W-1:0];
		wr(8'h0a, 8'h81);
		chk("staged lane", {1'b0, applied}, {1'b0, lcfg});
		chk("staged eq", 16'h0003, {14'h0, leq, lada});
		c0 = pulses;
		wr(8'h0a, 8'h85);
		chk("commit lane", {1'b0, pend}, {1'b0, lcfg});
		chk("commit eq", 16'h0000, {14'h0, leq, lada});
		chk("commit pulse", 16'h0001, 16'(pulses - c0));
		rd(8'h0a, q);
		chk("commit reads zero", 16'h0081, {8'h00, q});
		prevm = 2'b01;
		for (int m = 0; m < 4; m++) begin
			d = 8'hb0 | 8'(m);
			wr(8'h0a, d);
			chk("mode held", {14'h0, prevm}, {14'h0, fm});
			fpd = 1'b1;
			repeat (8) @(negedge clk_i);
			fpd = 1'b0;
			repeat (8) @(negedge clk_i);
			prevm = d[1:0];
			chk("mode applied", {14'h0, prevm}, {14'h0, fm});
		end
		wr(8'h0b, 8'hff);
		rd(8'h0b, q);
		chk("unmapped read", 16'h0000, {8'h00, q});
		host.wr_reg(7'h2d, 8'h0a, 8'h00, ok);
		chk("foreign ack", 16'h0000, {15'h0, ok});
		rd(8'h0a, q);
		chk("register kept", 16'h00b3, {8'h00, q});
		wrap_up();
	end
	// The whole sequence needs about 22500 clocks; this leaves ample margin.
	initial begin
		repeat (90000) @(posedge clk_i);
		mismatches++;
		wrap_up();
	end
endmodule // rtmc_misc_regs_tb
